/* hdl/ops_pkg.sv */
// Constants shared by the on/off power sequencer
package ops_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PITCH    = 8'h04;
  localparam logic [7:0] OFS_OPT      = 8'h08;
  localparam logic [7:0] OFS_POFF_LOG = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_SLV_BASE = 8'h40;
  // Control register fields
  localparam int CTRL_GLP      = 0;
  localparam int CTRL_SRC_SW   = 1;
  localparam int CTRL_SW_EN    = 4;
  localparam int CTRL_CHG_ALT  = 7;
  localparam int CTRL_OSC_MODE = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_03FF;
  // Pitch register fields, three bits each
  localparam int PITCH_PU  = 0;
  localparam int PITCH_PD  = 4;
  localparam int PITCH_SEN = 8;
  localparam int PITCH_SEX = 12;
  localparam logic [31:0] PITCH_MASK = 32'h0000_7777;
  // Option register: polarity bits and lock
  localparam int OPT_ONKEY_AL = 0;
  localparam int OPT_SLEEP_AL = 1;
  localparam int OPT_CHG_AL   = 2;
  localparam int OPT_SHUTDOWN_IN_AL  = 3;
  localparam int OPT_LOCK     = 31;
  localparam logic [31:0] OPT_MASK = 32'h8000_000F;
  // Power-off cause log fields
  localparam int LOG_SHUTDOWN_IN = 0;
  // Slave config fields
  localparam int SLV_SRC  = 0;
  localparam int SLV_SLOT = 2;
  localparam int SLV_SW   = 5;
  localparam int SLV_MODE = 6;
  localparam logic [31:0] SLV_MASK = 32'h0000_00FF;
  localparam logic [1:0] SRC_SOFTWARE = 2'b11;
  // Slaves: four gpios, reset pin, thirteen regulators
  localparam int N_GPIO = 4;
  localparam int N_REG  = 13;
  localparam int SLV_RST = N_GPIO;
  localparam int N_SLV  = N_GPIO + 1 + N_REG;
  localparam int N_MSTR = 3;
  localparam int N_SYNC = 7;
  // Power mode field codes
  localparam logic [1:0] MODE_OFF  = 2'b00;
  localparam logic [1:0] MODE_AUTO = 2'b01;
  localparam logic [1:0] MODE_LP   = 2'b10;
  // Slot pitch table in microseconds
  localparam int unsigned PITCH_US [8] = '{31, 61, 122, 244, 488, 976, 1952, 3904};
  localparam int unsigned CLK_MHZ = 20;
  localparam int CNT_W = 17;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage : ops_pkg

/* hdl/ops_seq_timer.sv */
// One master sequencing timer stepping eight slots
`timescale 1ns/1ps
`default_nettype none
module ops_seq_timer #(
  parameter int unsigned CYC_PER_US = ops_pkg::CLK_MHZ
) (
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic       clear_in,
  input  wire logic       enable_in,
  input  wire logic [2:0] pitch_up_in,
  input  wire logic [2:0] pitch_dn_in,
  output logic      [7:0] slot_on_out
);
  logic [ops_pkg::CNT_W-1:0] cnt;
  logic [ops_pkg::CNT_W-1:0] reload;
  logic [7:0]                next_slot_on;
  logic                      pending;
  logic [2:0]                pitch_sel;

  // Slots fill from 0 upward and empty from 7 downward; a reversal mid-way just turns back
  assign pending      = enable_in ? ~slot_on_out[7] : slot_on_out[0];
  assign pitch_sel    = enable_in ? pitch_up_in : pitch_dn_in;
  assign reload       = ops_pkg::CNT_W'(ops_pkg::PITCH_US[pitch_sel] * CYC_PER_US - 1);
  assign next_slot_on = enable_in ? {slot_on_out[6:0], 1'b1} : {1'b0, slot_on_out[7:1]};

  // Counter on the device clock; one slot edge per pitch
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cnt         <= '0;
      slot_on_out <= 8'h00;
    end
    else if (clear_in)
    begin
      cnt         <= '0;
      slot_on_out <= 8'h00;
    end
    else if (pending && cnt == '0)
    begin
      slot_on_out <= next_slot_on;
      cnt         <= reload;
    end
    else if (cnt != '0)
    begin
      cnt <= cnt - 1'b1;
    end
  end
endmodule : ops_seq_timer
`default_nettype wire

/* hdl/ops_sequencer.sv */
// On/off controller, flexible power sequencer and power mode decode
// Function
// - On-key polarity from programmed option bit
// - Sleep enable input, programmed polarity, controls sleep
// - Charger input polarity and matching pull resistor
// - Asserted shutdown input forces global shutdown
// - Shutdown-input cause logged in power-off recorder
// - Battery under lockout blocks wakeups to masters a and b; master c takes the charger input directly
// - Battery below minimum blocks all masters
// - Regulator gate and mode decode with low-power
// - Oscillator mode decode: off, auto, low-power, low-jitter
// - Log bits clear only by writing one
// - Recorder has no mask, never drives interrupt
// - Log survives global shutdown while backup valid
// - Four gpios and reset pin act as slaves
// - Separate three-bit pitch per phase
// - Three masters, hardware or software source
// - Master produces eight events spaced by pitch
// - Per-slave source select and slot
// - Slots rise 0 to 7, fall 7 to 0
// - Pitch 31 to 3904 us, binary weighted
// - Slaves turn on up, off down, in slot
`timescale 1ns/1ps
`default_nettype none
module ops_sequencer #(
  parameter int unsigned CYC_PER_US = ops_pkg::CLK_MHZ
) (
  input  wire logic                       mclk_in,
  input  wire logic                       rst_b_in,
  input  wire logic                       psel_in,
  input  wire logic                       penable_in,
  input  wire logic                       pwrite_in,
  input  wire logic [7:0]                 paddr_in,
  input  wire logic [31:0]                pwdata_in,
  output logic      [31:0]                prdata_out,
  output logic                            pready_out,
  output logic                            pslverr_out,
  input  wire logic                       onkey_enable_in,
  input  wire logic                       proc_sleep_enable_in,
  input  wire logic                       charger_present_in,
  input  wire logic                       shutdown_in,
  input  wire logic                       battery_above_uvlo_in,
  input  wire logic                       battery_below_min_in,
  input  wire logic                       bidir_reset_pin_in,
  output logic                            bidir_reset_pin_out,
  output logic                            bidir_reset_pin_oe_out,
  output logic [ops_pkg::N_GPIO-1:0]      gpio_seq_out,
  output logic [ops_pkg::N_REG-1:0]       reg_enable_out,
  output logic [ops_pkg::N_REG-1:0]       reg_low_power_out,
  output logic                            osc32k_enable_out,
  output logic                            osc32k_low_power_out,
  output logic                            charger_pullup_out,
  output logic                            charger_pulldown_out,
  output logic                            global_shutdown_out
);
  localparam int NS = ops_pkg::N_SLV;

  // Decode a two-bit mode field into {on, low_power}
  function automatic logic [1:0] mode_decode(input logic [1:0] mode, input logic glp);
    logic [1:0] res;
    case (mode)
      ops_pkg::MODE_OFF:  res = 2'b00;
      ops_pkg::MODE_AUTO: res = {1'b1, glp};
      ops_pkg::MODE_LP:   res = 2'b11;
      default:            res = 2'b10;
    endcase
    return res;
  endfunction : mode_decode

  logic [31:0] ctrl;
  logic [31:0] pitch;
  logic [31:0] opt;
  logic [31:0] poff_log;
  logic [31:0] slv_cfg [NS];
  logic [ops_pkg::N_SYNC-1:0] sync_a;
  logic [ops_pkg::N_SYNC-1:0] sync_b;
  logic        shutdown_in_prev;
  logic        wake;

  // Pin synchroniser, second stage only is read
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= {bidir_reset_pin_in, battery_below_min_in, battery_above_uvlo_in, shutdown_in,
                 charger_present_in, proc_sleep_enable_in, onkey_enable_in};
      sync_b <= sync_a;
    end
  end

  // Polarity applied after synchronising
  wire onkey_act  = sync_b[0] ^ opt[ops_pkg::OPT_ONKEY_AL];
  wire sleep_act  = sync_b[1] ^ opt[ops_pkg::OPT_SLEEP_AL];
  wire chg_act    = (sync_b[2] ^ opt[ops_pkg::OPT_CHG_AL]) & ctrl[ops_pkg::CTRL_CHG_ALT];
  wire shutdown_in_act   = sync_b[3] ^ opt[ops_pkg::OPT_SHUTDOWN_IN_AL];
  wire batt_ok    = sync_b[4];
  wire batt_low   = sync_b[5];
  wire rst_pin    = sync_b[6];
  wire glb_shutdown_in   = shutdown_in_act & ~shutdown_in_prev;
  wire glp        = ctrl[ops_pkg::CTRL_GLP];

  // APB decode; pready answers one cycle into the access phase
  wire        access   = psel_in & penable_in;
  wire        fire     = access & pready_out;
  wire        wr_fire  = fire & pwrite_in;
  wire        slv_hit  = paddr_in >= ops_pkg::OFS_SLV_BASE && paddr_in[1:0] == 2'b00 &&
                         paddr_in < ops_pkg::OFS_SLV_BASE + 8'(4 * NS);
  wire [7:0]  slv_ofs  = paddr_in - ops_pkg::OFS_SLV_BASE;
  wire [4:0]  slv_idx  = slv_ofs[6:2];
  wire        hit_ctrl = paddr_in == ops_pkg::OFS_CTRL;
  wire        hit_pit  = paddr_in == ops_pkg::OFS_PITCH;
  wire        hit_opt  = paddr_in == ops_pkg::OFS_OPT;
  wire        hit_log  = paddr_in == ops_pkg::OFS_POFF_LOG;
  wire        hit_stat = paddr_in == ops_pkg::OFS_STATUS;
  wire        mapped   = hit_ctrl | hit_pit | hit_opt | hit_log | hit_stat | slv_hit;

  // Master enables: wakeups gated by lockout for masters a and b, charger direct to c, all gated by battery low
  wire        wake_src = onkey_act | chg_act;
  wire [2:0]  hw_en    = {chg_act, wake & sleep_act, wake};
  logic [2:0] mstr_en;
  logic [7:0] slot_on [ops_pkg::N_MSTR];
  wire [2:0]  pit_up [ops_pkg::N_MSTR];
  wire [2:0]  pit_dn [ops_pkg::N_MSTR];
  assign pit_up[0] = pitch[ops_pkg::PITCH_PU +: 3];
  assign pit_dn[0] = pitch[ops_pkg::PITCH_PD +: 3];
  assign pit_up[1] = pitch[ops_pkg::PITCH_SEX +: 3];
  assign pit_dn[1] = pitch[ops_pkg::PITCH_SEN +: 3];
  assign pit_up[2] = pitch[ops_pkg::PITCH_PU +: 3];
  assign pit_dn[2] = pitch[ops_pkg::PITCH_PD +: 3];

  genvar m;
  generate
    for (m = 0; m < ops_pkg::N_MSTR; m++)
    begin : g_mstr
      // Source select per master, then the battery-low veto
      assign mstr_en[m] = (ctrl[ops_pkg::CTRL_SRC_SW + m] ? ctrl[ops_pkg::CTRL_SW_EN + m] : hw_en[m])
                          & ~batt_low;
      ops_seq_timer #(
        .CYC_PER_US (CYC_PER_US)
      ) u_timer (
        .mclk_in     (mclk_in),
        .rst_b_in    (rst_b_in),
        .clear_in    (glb_shutdown_in),
        .enable_in   (mstr_en[m]),
        .pitch_up_in (pit_up[m]),
        .pitch_dn_in (pit_dn[m]),
        .slot_on_out (slot_on[m])
      );
    end
  endgenerate

  // Per-slave gate: chosen master's slot, or software when source is 0b11
  logic [NS-1:0] slv_on;
  logic [NS-1:0] slv_lp;
  genvar s;
  generate
    for (s = 0; s < NS; s++)
    begin : g_slv
      wire [1:0] src     = slv_cfg[s][ops_pkg::SLV_SRC +: 2];
      wire [2:0] slot    = slv_cfg[s][ops_pkg::SLV_SLOT +: 3];
      wire       is_sw   = src == ops_pkg::SRC_SOFTWARE;
      wire [1:0] msel    = is_sw ? 2'b00 : src;
      wire       seq_en  = slot_on[msel][slot];
      wire [1:0] md      = mode_decode(slv_cfg[s][ops_pkg::SLV_MODE +: 2], glp);
      if (s <= ops_pkg::SLV_RST)
      begin : g_pin
        // Pins: sequencer level, or the software bit
        assign slv_on[s] = is_sw ? slv_cfg[s][ops_pkg::SLV_SW] : seq_en;
        assign slv_lp[s] = 1'b0;
      end
      else
      begin : g_reg
        assign slv_on[s] = md[1] & (is_sw | seq_en);
        assign slv_lp[s] = md[0] & (is_sw | seq_en);
      end
    end
  endgenerate

  wire [1:0] osc_md = mode_decode(ctrl[ops_pkg::CTRL_OSC_MODE +: 2], glp);

  // Status word shows synced inputs and every master's slots
  wire [31:0] status = {slot_on[2], slot_on[1], slot_on[0], rst_pin, wake, batt_low, batt_ok,
                        shutdown_in_act, chg_act, sleep_act, onkey_act};
  wire [31:0] rd_mux = hit_ctrl ? ctrl :
                       hit_pit  ? pitch :
                       hit_opt  ? opt :
                       hit_log  ? poff_log :
                       hit_stat ? status :
                       slv_hit  ? slv_cfg[slv_idx] : ops_pkg::RESET_ZERO;

  // Bus answer registers
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
    end
    else
    begin
      pready_out  <= access & ~pready_out;
      pslverr_out <= access & ~pready_out & ~mapped;
      prdata_out  <= (access & ~pready_out & ~pwrite_in) ? rd_mux : ops_pkg::RESET_ZERO;
    end
  end

  // Options are writable until locked; kept through global shutdown like fuses
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      opt <= ops_pkg::RESET_ZERO;
    else if (wr_fire && hit_opt && !opt[ops_pkg::OPT_LOCK])
      opt <= pwdata_in & ops_pkg::OPT_MASK;
  end

  // Cause log: set wins over clear; only the backup reset clears it otherwise
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      poff_log <= ops_pkg::RESET_ZERO;
    else
      poff_log <= (poff_log & ~((wr_fire && hit_log) ? pwdata_in : ops_pkg::RESET_ZERO))
                  | (32'(glb_shutdown_in) << ops_pkg::LOG_SHUTDOWN_IN);
  end

  // Working registers return to reset on global shutdown
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ctrl      <= ops_pkg::RESET_ZERO;
      pitch     <= ops_pkg::RESET_ZERO;
      shutdown_in_prev <= 1'b0;
      wake      <= 1'b0;
    end
    else
    begin
      shutdown_in_prev <= shutdown_in_act;
      if (glb_shutdown_in)
      begin
        ctrl  <= ops_pkg::RESET_ZERO;
        pitch <= ops_pkg::RESET_ZERO;
        wake  <= 1'b0;
      end
      else
      begin
        if (wake_src && batt_ok)
          wake <= 1'b1;
        if (wr_fire && hit_ctrl)
          ctrl <= pwdata_in & ops_pkg::CTRL_MASK;
        if (wr_fire && hit_pit)
          pitch <= pwdata_in & ops_pkg::PITCH_MASK;
      end
    end
  end

  // Slave config words
  generate
    for (s = 0; s < NS; s++)
    begin : g_cfg
      always_ff @(posedge mclk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
          slv_cfg[s] <= ops_pkg::RESET_ZERO;
        else if (glb_shutdown_in)
          slv_cfg[s] <= ops_pkg::RESET_ZERO;
        else if (wr_fire && slv_hit && slv_idx == 5'(s))
          slv_cfg[s] <= pwdata_in & ops_pkg::SLV_MASK;
      end
    end
  endgenerate

  // Registered outputs; reset pin is open drain, pulled low while its slave is off
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      gpio_seq_out           <= '0;
      reg_enable_out         <= '0;
      reg_low_power_out      <= '0;
      bidir_reset_pin_out    <= 1'b0;
      bidir_reset_pin_oe_out <= 1'b1;
      osc32k_enable_out      <= 1'b0;
      osc32k_low_power_out   <= 1'b0;
      charger_pullup_out     <= 1'b0;
      charger_pulldown_out   <= 1'b0;
      global_shutdown_out    <= 1'b0;
    end
    else
    begin
      gpio_seq_out           <= slv_on[ops_pkg::N_GPIO-1:0];
      reg_enable_out         <= slv_on[NS-1:ops_pkg::SLV_RST+1];
      reg_low_power_out      <= slv_lp[NS-1:ops_pkg::SLV_RST+1];
      bidir_reset_pin_out    <= 1'b0;
      bidir_reset_pin_oe_out <= ~slv_on[ops_pkg::SLV_RST];
      osc32k_enable_out      <= osc_md[1];
      osc32k_low_power_out   <= osc_md[0];
      charger_pullup_out     <= ctrl[ops_pkg::CTRL_CHG_ALT] & opt[ops_pkg::OPT_CHG_AL];
      charger_pulldown_out   <= ctrl[ops_pkg::CTRL_CHG_ALT] & ~opt[ops_pkg::OPT_CHG_AL];
      global_shutdown_out    <= glb_shutdown_in;
    end
  end
  // No interrupt output exists; the cause log has no mask or status companion
endmodule : ops_sequencer
`default_nettype wire

/* tb/ops_chk_assertions.sv */
// Port-level concurrent checks for the on/off sequencer
`timescale 1ns/1ps
`default_nettype none
module ops_chk #(
  parameter int unsigned CYC_PER_US = ops_pkg::CLK_MHZ
) (
  input wire logic        mclk_in,
  input wire logic        rst_b_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        bidir_reset_pin_out,
  input wire logic [12:0] reg_enable_out,
  input wire logic [12:0] reg_low_power_out,
  input wire logic        osc32k_enable_out,
  input wire logic        osc32k_low_power_out,
  input wire logic        charger_pullup_out,
  input wire logic        charger_pulldown_out,
  input wire logic        global_shutdown_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // Access phase still waiting, then a single-cycle answer
  sequence s_wait;
    psel_in && penable_in && !pready_out;
  endsequence
  sequence s_pulse;
    pready_out ##1 !pready_out;
  endsequence
  chk_ready_one_wait: assert property (s_wait |=> s_pulse)
    else $error("answer not one cycle after access");
  chk_setup_no_ready: assert property (psel_in && !penable_in |-> !pready_out)
    else $error("answer during setup");
  chk_rdata_idle_zero: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data outside answer");
  chk_err_with_ready: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0000_0000)
    else $error("error without answer");
  chk_shutdown_in_one_pulse: assert property (global_shutdown_out |=> !global_shutdown_out [*2])
    else $error("shutdown pulse too long");
  chk_reg_lp_on: assert property ((reg_low_power_out & ~reg_enable_out) == 13'h0000)
    else $error("regulator low power while off");
  chk_osc_lp_on: assert property (osc32k_low_power_out |-> osc32k_enable_out)
    else $error("oscillator low power while off");
  chk_pull_one_way: assert property (!(charger_pullup_out && charger_pulldown_out))
    else $error("both charger pulls on");
  chk_rst_pin_low: assert property (!bidir_reset_pin_out)
    else $error("reset pin driven high");
endmodule : ops_chk
bind ops_sequencer ops_chk #(.CYC_PER_US(CYC_PER_US)) u_chk (.mclk_in, .rst_b_in, .psel_in, .penable_in,
  .prdata_out, .pready_out, .pslverr_out, .bidir_reset_pin_out, .reg_enable_out, .reg_low_power_out,
  .osc32k_enable_out, .osc32k_low_power_out, .charger_pullup_out, .charger_pulldown_out, .global_shutdown_out);
`default_nettype wire

/* tb/ops_proc_model.sv */
// Processor, on-key, charger and sensor pins facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module ops_proc_model (
  input  wire logic [3:0] assert_in,
  input  wire logic [3:0] active_low_in,
  input  wire logic       reset_pull_in,
  output logic            onkey_out,
  output logic            sleep_out,
  output logic            charger_out,
  output logic            shutdown_out,
  output logic            reset_line_out
);
  // Asserted level follows each pin's programmed polarity
  assign onkey_out    = assert_in[0] ^ active_low_in[0];
  assign sleep_out    = assert_in[1] ^ active_low_in[1];
  assign charger_out  = assert_in[2] ^ active_low_in[2];
  assign shutdown_out = assert_in[3] ^ active_low_in[3];
  // Open-drain reset line, pulled up when nobody sinks it
  assign reset_line_out = !reset_pull_in;
endmodule : ops_proc_model
`default_nettype wire

/* tb/onoff_sequencer_power_mode_tb.sv */
// Self-checking bench for the on/off sequencer
`timescale 1ns/1ps
`default_nettype none
module onoff_sequencer_power_mode_tb;
  localparam int unsigned CYC = 1;
  typedef struct packed {logic [1:0] mode; logic glp; logic en; logic lp;} ops_row_t;
  // Rows: mode, global low power, expected on, expected low power
  localparam ops_row_t ROWS [8] = '{5'h00, 5'h04, 5'h0A, 5'h0F, 5'h13, 5'h17, 5'h1A, 5'h1E};
  logic        mclk_in, rst_b_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, er;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic        onkey_enable_in, proc_sleep_enable_in, charger_present_in, shutdown_in;
  logic        battery_above_uvlo_in, battery_below_min_in, bidir_reset_pin_in, bidir_reset_pin_out;
  logic        bidir_reset_pin_oe_out, osc32k_enable_out, osc32k_low_power_out, charger_pullup_out;
  logic        charger_pulldown_out, global_shutdown_out;
  logic [3:0]  gpio_seq_out, pin_req, pin_al;
  logic [12:0] reg_enable_out, reg_low_power_out;
  int          errors, checks_done, n;

  ops_sequencer #(.CYC_PER_US(CYC)) DUT (.mclk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .onkey_enable_in, .proc_sleep_enable_in,
    .charger_present_in, .shutdown_in, .battery_above_uvlo_in, .battery_below_min_in, .bidir_reset_pin_in,
    .bidir_reset_pin_out, .bidir_reset_pin_oe_out, .gpio_seq_out, .reg_enable_out, .reg_low_power_out,
    .osc32k_enable_out, .osc32k_low_power_out, .charger_pullup_out, .charger_pulldown_out, .global_shutdown_out);
  ops_proc_model PARTNER (.assert_in(pin_req), .active_low_in(pin_al), .reset_pull_in(bidir_reset_pin_oe_out),
    .onkey_out(onkey_enable_in), .sleep_out(proc_sleep_enable_in), .charger_out(charger_present_in),
    .shutdown_out(shutdown_in), .reset_line_out(bidir_reset_pin_in));

  // 20 MHz clock
  initial
  begin
    mclk_in = 1'h0;
    forever #25 mclk_in = ~mclk_in;
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // One APB transfer; waits for the answer, never a fixed count
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_in);
    psel_in    <= 1'h1;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge mclk_in);
    penable_in <= 1'h1;
    do
    begin
      @(posedge mclk_in);
      k++;
    end
    while (pready_out !== 1'h1 && k < 8);
    rd = prdata_out;
    er = pslverr_out;
    psel_in    <= 1'h0;
    penable_in <= 1'h0;
    if (k >= 8)
    begin
      errors++;
      summarize();
    end
  endtask : apb

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'h0, a, 32'h0000_0000);
    check(nm, exp, rd);
  endtask : rd_check

  // Cycles until a sequenced pin reaches a level, bounded
  task automatic wait_gpio(input int i, input logic v);
    n = 0;
    while (gpio_seq_out[i] !== v && n < 2000)
    begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 2000)
    begin
      errors++;
      summarize();
    end
  endtask : wait_gpio

  // Main sequence
  initial
  begin
    errors = 0;
    checks_done = 0;
    rst_b_in = 1'h0;
    {psel_in, penable_in, pwrite_in} = 3'h0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0000_0000;
    {pin_req, pin_al} = 8'h00;
    {battery_above_uvlo_in, battery_below_min_in} = 2'h0;
    repeat (2) @(posedge mclk_in);
    rst_b_in <= 1'h1;
    @(posedge mclk_in);
    check("reset pin sink", 32'h1, bidir_reset_pin_oe_out);
    rd_check(ops_pkg::OFS_POFF_LOG, 32'h0000_0000, "log at init");
    apb(1'h0, 8'h20, 32'h0000_0000);
    check("unmapped err", 32'h1, er);
    // Wake while battery under lockout, then with battery good
    pin_req[0] <= 1'h1;
    repeat (60) @(posedge mclk_in);
    check("gpio locked out", 32'h0, gpio_seq_out);
    battery_above_uvlo_in <= 1'h1;
    wait_gpio(3, 1'h1);
    check("gpio woke", 32'h0000_000F, gpio_seq_out);
    pin_req[0] <= 1'h0;
    apb(1'h1, ops_pkg::OFS_PITCH, 32'h0000_2310);
    rd_check(ops_pkg::OFS_PITCH, 32'h0000_2310, "pitch fields");
    // Shutdown pin, then sticky write-one-to-clear log
    pin_req[3] <= 1'h1;
    n = 0;
    while (global_shutdown_out !== 1'h1 && n < 20)
    begin
      @(posedge mclk_in);
      n++;
    end
    check("shutdown pulse", 32'h1, global_shutdown_out);
    if (n >= 20)
      summarize();
    pin_req[3] <= 1'h0;
    rd_check(ops_pkg::OFS_PITCH, 32'h0000_0000, "pitch cleared");
    rd_check(ops_pkg::OFS_POFF_LOG, 32'h0000_0001, "log set");
    apb(1'h1, ops_pkg::OFS_POFF_LOG, 32'h0000_0000);
    rd_check(ops_pkg::OFS_POFF_LOG, 32'h0000_0001, "log kept");
    apb(1'h1, ops_pkg::OFS_POFF_LOG, 32'h0000_0001);
    rd_check(ops_pkg::OFS_POFF_LOG, 32'h0000_0000, "log cleared");
    // Mode decode table on regulator 0 and the oscillator
    foreach (ROWS[i])
    begin
      apb(1'h1, ops_pkg::OFS_CTRL, {22'h00_0000, ROWS[i].mode, 7'h00, ROWS[i].glp});
      apb(1'h1, ops_pkg::OFS_SLV_BASE + 8'h14, {24'h00_0000, ROWS[i].mode, 6'h03});
      repeat (3) @(posedge mclk_in);
      check("reg on", {31'h0, ROWS[i].en}, reg_enable_out[0]);
      check("reg lp", {31'h0, ROWS[i].lp}, reg_low_power_out[0]);
      check("osc on", {31'h0, ROWS[i].en}, osc32k_enable_out);
      check("osc lp", {31'h0, ROWS[i].lp}, osc32k_low_power_out);
    end
    apb(1'h1, ops_pkg::OFS_SLV_BASE + 8'h14, 32'h0000_00C0);
    repeat (3) @(posedge mclk_in);
    check("reg gated", 32'h0, reg_enable_out[0]);
    // Software master, slots 2 and 5, battery low veto first
    wait_gpio(0, 1'h0);
    battery_below_min_in <= 1'h1;
    apb(1'h1, ops_pkg::OFS_PITCH, 32'h0000_2310);
    apb(1'h1, ops_pkg::OFS_SLV_BASE, 32'h0000_0008);
    apb(1'h1, ops_pkg::OFS_SLV_BASE + 8'h04, 32'h0000_0014);
    apb(1'h1, ops_pkg::OFS_SLV_BASE + 8'h10, 32'h0000_0023);
    apb(1'h1, ops_pkg::OFS_CTRL, 32'h0000_0012);
    repeat (60) @(posedge mclk_in);
    check("veto", 32'h0, gpio_seq_out[1:0]);
    check("reset pin sw", 32'h0, bidir_reset_pin_oe_out);
    battery_below_min_in <= 1'h0;
    wait_gpio(0, 1'h1);
    wait_gpio(1, 1'h1);
    check("up gap", 3 * 31 * CYC, n);
    apb(1'h1, ops_pkg::OFS_CTRL, 32'h0000_0002);
    wait_gpio(1, 1'h0);
    wait_gpio(0, 1'h0);
    check("down gap", 3 * 61 * CYC, n);
    // Slot 0 empties last, so master a is fully off before status is read
    wait_gpio(2, 1'h0);
    // Polarity options, charger pull, then the lock
    pin_al <= 4'h5;
    pin_req[0] <= 1'h1;
    apb(1'h1, ops_pkg::OFS_OPT, 32'h8000_0005);
    apb(1'h1, ops_pkg::OFS_CTRL, 32'h0000_0082);
    rd_check(ops_pkg::OFS_STATUS, 32'h0000_00D1, "onkey low") ;
    check("pull up", 32'h2, {charger_pullup_out, charger_pulldown_out});
    apb(1'h1, ops_pkg::OFS_OPT, 32'h0000_0000);
    rd_check(ops_pkg::OFS_OPT, 32'h8000_0005, "option lock");
    // Sleep enable drives master b once a wakeup is latched
    apb(1'h1, ops_pkg::OFS_SLV_BASE + 8'h08, 32'h0000_0001);
    pin_req[1] <= 1'h1;
    wait_gpio(2, 1'h1);
    check("sleep exit", 32'h1, gpio_seq_out[2]);
    summarize();
  end
endmodule : onoff_sequencer_power_mode_tb
`default_nettype wire
